// *** shared/tcae_pkg.sv ***
// Purpose: Shared constants and types for the touch calibration and alert enable block
// Assumes: 50 MHz system clock, eight sense inputs
// Notes:   Offsets are byte addresses on the serial register port
`default_nettype none
package tcae_pkg;

  localparam int          NCH           = 8;
  localparam int          CH_W          = 3;
  localparam int          CAL_W         = 10;
  localparam int          CNT_W         = 5;
  localparam int          SET_W         = 4;

  // Register offsets
  localparam logic [7:0]  ADDR_CAL_REQ  = 8'h26;
  localparam logic [7:0]  ADDR_ALERT_EN = 8'h27;
  localparam logic [7:0]  ADDR_RPT_EN   = 8'h28;
  localparam logic [7:0]  UNMAPPED_RD   = 8'h00;

  // Reset values
  localparam logic [7:0]  CAL_REQ_RST   = 8'h00;
  localparam logic [7:0]  ALERT_EN_RST  = 8'hff;
  localparam logic [7:0]  RPT_EN_RST    = 8'hff;

  // Calibration value limits
  localparam logic [CAL_W-1:0] CAL_MAX  = 10'h3ff;
  localparam logic [CAL_W-1:0] CAL_MIN  = 10'h000;

  // Timing: 35 ms setting step
  localparam int          STEP_TIME_MS  = 35;
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          STEP_CYCLES   = STEP_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic {TCAE_SEQ_IDLE, TCAE_SEQ_RUN} tcae_seq_st_t;
  typedef enum logic {TCAE_TMR_IDLE, TCAE_TMR_TOUCHED} tcae_tmr_st_t;

  // Lowest set bit, ascending channel order
  function automatic logic [CH_W-1:0] tcae_lowest(input logic [NCH-1:0] v);
    logic [CH_W-1:0] idx;
    idx = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CH_W'(i);
      end
    end
    return idx;
  endfunction : tcae_lowest

endpackage : tcae_pkg
`default_nettype wire

// *** verilog/tcae_cal_seq.sv ***
// Purpose: Picks pending channels one at a time and runs the calibration engine
// Assumes: Engine answers each start with one cal_done pulse
// Notes:   Channel number holds steady while busy
`timescale 1ns/1ps
`default_nettype none
module tcae_cal_seq (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Work to do
  input  wire logic [tcae_pkg::NCH-1:0] pending,
  // Engine handshake
  input  wire logic                     cal_done,
  output logic                          cal_start,
  output logic [tcae_pkg::CH_W-1:0]     cal_channel,
  output logic                          cal_busy
);
  import tcae_pkg::*;

  tcae_seq_st_t    st_q, st_d;
  logic            start_q, start_d;
  logic [CH_W-1:0] ch_q, ch_d;

  always_comb begin
    st_d    = st_q;
    start_d = 1'b0;
    ch_d    = ch_q;
    case (st_q)
      TCAE_SEQ_IDLE: begin
        if (|pending) begin
          ch_d    = tcae_lowest(pending);
          start_d = 1'b1;
          st_d    = TCAE_SEQ_RUN;
        end
      end
      TCAE_SEQ_RUN: begin
        if (cal_done) begin
          st_d = TCAE_SEQ_IDLE;
        end
      end
      default: st_d = TCAE_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= TCAE_SEQ_IDLE;
      start_q <= 1'b0;
      ch_q    <= '0;
    end else begin
      st_q    <= st_d;
      start_q <= start_d;
      ch_q    <= ch_d;
    end
  end

  assign cal_start   = start_q;
  assign cal_channel = ch_q;
  assign cal_busy    = (st_q == TCAE_SEQ_RUN);

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_order;
    (st_q == TCAE_SEQ_IDLE) && (|pending)
      |=> cal_start && (cal_channel == tcae_lowest($past(pending)));
  endproperty
  a_order: assert property (p_order) else $error("Wrong channel order");

endmodule : tcae_cal_seq
`default_nettype wire

// *** verilog/tcae_rpt_chan.sv ***
// Purpose: Per-channel interrupt timing for touch, release and press-and-hold
// Assumes: tick is a one-cycle pulse every 35 ms step
// Notes:   Counters saturate so a very long hold never wraps
`timescale 1ns/1ps
`default_nettype none
module tcae_rpt_chan #(
  parameter int CNT_W = tcae_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Timing and settings
  input  wire logic                       tick,
  input  wire logic                       repeat_en,
  input  wire logic                       rel_en,
  input  wire logic [tcae_pkg::SET_W-1:0] repeat_interval,
  input  wire logic [tcae_pkg::SET_W-1:0] min_press_time,
  // Touch and event
  input  wire logic                       touched,
  output logic                            event_q
);
  import tcae_pkg::*;

  tcae_tmr_st_t     st_q, st_d;
  logic [CNT_W-1:0] press_q, press_d, rep_q, rep_d;
  logic             event_d;
  logic [CNT_W-1:0] press_inc, rep_inc;
  logic             hold;

  always_comb begin
    st_d      = st_q;
    press_d   = press_q;
    rep_d     = rep_q;
    event_d   = 1'b0;
    press_inc = (&press_q) ? press_q : press_q + CNT_W'(1);
    rep_inc   = (&rep_q) ? rep_q : rep_q + CNT_W'(1);
    // Touch counts as hold only once longer than the minimum press
    hold      = press_inc > (CNT_W'(min_press_time) + CNT_W'(1));
    case (st_q)
      TCAE_TMR_IDLE: begin
        if (touched) begin
          event_d = 1'b1;
          press_d = '0;
          rep_d   = '0;
          st_d    = TCAE_TMR_TOUCHED;
        end
      end
      TCAE_TMR_TOUCHED: begin
        if (!touched) begin
          event_d = rel_en;
          st_d    = TCAE_TMR_IDLE;
        end else if (tick) begin
          press_d = press_inc;
          rep_d   = rep_inc;
          if (repeat_en && hold &&
              rep_inc >= (CNT_W'(repeat_interval) + CNT_W'(1))) begin
            event_d = 1'b1;
            rep_d   = '0;
          end
        end
      end
      default: st_d = TCAE_TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= TCAE_TMR_IDLE;
      press_q <= '0;
      rep_q   <= '0;
      event_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      press_q <= press_d;
      rep_q   <= rep_d;
      event_q <= event_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_once;
    !repeat_en && (st_q == TCAE_TMR_TOUCHED) && touched |=> !event_q;
  endproperty
  a_once: assert property (p_once) else $error("Repeat while disabled");

  property p_touch;
    (st_q == TCAE_TMR_IDLE) && touched |=> event_q ##1 !event_q;
  endproperty
  a_touch: assert property (p_touch) else $error("Touch event missing");

endmodule : tcae_rpt_chan
`default_nettype wire

// *** verilog/tcae_top.sv ***
// Purpose: Calibration request, alert enable and auto-repeat enable registers
// Assumes: Register port and status inputs come from logic on clk
// Notes:   Sensing core and analog calibration engine sit outside
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Writing one to a request bit calibrates that input, analog and digital.
// - Analog calibration done updates that channel's ten-bit calibration value.
// - Successful calibration clears the channel's request bit by hardware.
// - Newly enabled inputs set their request bit, including after reset.
// - A request bit left set after calibration raises the failure flag.
// - Noise or calibration value at limit means failure; bit stays set.
// - With failure flag set, a still-set bit marks that channel failed.
// - Writing zero clears a bit; a pending calibration is then skipped.
// - Request register resets to zero; bit 7 is input 8.
// - Alert enable one lets a touch assert the alert pin; resets to ones.
// - Alert enable also gates release interrupts for its channel.
// - Alert enable bit n-1 belongs to sense input n.
// - Repeat disabled: one interrupt at touch, one at enabled release.
// - Repeat enabled, short touch: interrupt at touch and enabled release.
// - Repeat enabled, press-and-hold: interrupt at touch then each interval.
// - Repeat enable register has one bit per input; resets to ones.
// - Repeat interval is four bits of 35 ms steps, 35 to 560 ms.
// - Touch longer than minimum press time counts as press-and-hold.
module tcae_top #(
  parameter int unsigned STEP_CYCLES = tcae_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                                          clk,
  input  wire logic                                          arst_n,
  // Register port
  input  wire logic [7:0]                                    reg_addr,
  input  wire logic                                          reg_wr_en,
  input  wire logic                                          reg_rd_en,
  input  wire logic [7:0]                                    reg_wdata,
  output logic      [7:0]                                    reg_rdata,
  // Channel enables and power state
  input  wire logic [tcae_pkg::NCH-1:0]                      active_enable,
  input  wire logic [tcae_pkg::NCH-1:0]                      standby_enable,
  input  wire logic                                          in_standby,
  input  wire logic                                          in_deep_sleep,
  // Calibration engine
  output logic                                               cal_start,
  output logic      [tcae_pkg::CH_W-1:0]                     cal_channel,
  input  wire logic                                          cal_done,
  input  wire logic [tcae_pkg::CAL_W-1:0]                    cal_result,
  input  wire logic [tcae_pkg::NCH-1:0]                      noise_flag,
  output logic      [tcae_pkg::NCH-1:0][tcae_pkg::CAL_W-1:0] calibration_value,
  // Status
  input  wire logic                                          status_clear,
  output logic                                               analog_calibration_failed,
  // Touch interrupts
  input  wire logic [tcae_pkg::NCH-1:0]                      touch_status,
  input  wire logic                                          release_interrupt_enable,
  input  wire logic [tcae_pkg::SET_W-1:0]                    repeat_interval,
  input  wire logic [tcae_pkg::SET_W-1:0]                    min_press_time,
  input  wire logic                                          alert_clear,
  output logic                                               alert_n
);
  import tcae_pkg::*;

  localparam int DIV_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;

  // Register state
  logic [NCH-1:0]             cal_req_q, cal_req_d;
  logic [NCH-1:0]             alert_en_q, alert_en_d;
  logic [NCH-1:0]             rpt_en_q, rpt_en_d;
  logic [7:0]                 rdata_q, rdata_d;
  logic                       fail_q, fail_d;
  logic [NCH-1:0]             tried_q, tried_d;
  logic [NCH-1:0][CAL_W-1:0]  cv_q, cv_d;
  logic [NCH-1:0]             en_prev_q, en_prev_d;
  // Alert and timing state
  logic                       alert_q, alert_d;
  logic [DIV_W-1:0]           div_q, div_d;
  logic                       tick_q, tick_d;
  // Decode and helpers
  logic                       wr_cal, wr_alert, wr_rpt;
  logic [NCH-1:0]             eff_en, new_en, chan_evt, gated_evt, seq_pending;
  logic                       cal_bad, cal_busy;

  // Effective enable for the current power state
  always_comb begin
    if (in_deep_sleep) begin
      eff_en = '0;
    end else if (in_standby) begin
      eff_en = standby_enable;
    end else begin
      eff_en = active_enable;
    end
  end

  // Previous enables reset to zero, so reset itself counts as newly enabled
  assign new_en    = eff_en & ~en_prev_q;
  assign en_prev_d = eff_en;

  // Write decode
  always_comb begin
    wr_cal   = 1'b0;
    wr_alert = 1'b0;
    wr_rpt   = 1'b0;
    if (reg_wr_en && reg_addr == ADDR_CAL_REQ) begin
      wr_cal = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_ALERT_EN) begin
      wr_alert = 1'b1;
    end else if (reg_wr_en && reg_addr == ADDR_RPT_EN) begin
      wr_rpt = 1'b1;
    end
  end

  // Failed channels are not retried until requested again
  assign seq_pending = cal_req_q & ~tried_q;
  assign cal_bad     = noise_flag[cal_channel] || cal_result == CAL_MAX ||
                       cal_result == CAL_MIN;

  tcae_cal_seq u_seq (
    .clk         (clk),
    .arst_n      (arst_n),
    .pending     (seq_pending),
    .cal_done    (cal_done),
    .cal_start   (cal_start),
    .cal_channel (cal_channel),
    .cal_busy    (cal_busy)
  );

  // Calibration request and failure
  always_comb begin
    cal_req_d = cal_req_q;
    tried_d   = tried_q;
    cv_d      = cv_q;
    fail_d    = fail_q;
    if (cal_done && cal_busy) begin
      cv_d[cal_channel]    = cal_result;
      tried_d[cal_channel] = 1'b1;
      if (!cal_bad) begin
        cal_req_d[cal_channel] = 1'b0;
      end
    end
    if (wr_cal) begin
      cal_req_d = reg_wdata;
      tried_d   = tried_d & ~reg_wdata;
    end
    // Hardware set wins over a host write of zero
    cal_req_d = cal_req_d | new_en;
    tried_d   = tried_d & ~new_en;
    if (status_clear) begin
      fail_d = 1'b0;
    end
    // Event wins over a clear in the same cycle
    if (cal_done && cal_busy && cal_bad && cal_req_q[cal_channel]) begin
      fail_d = 1'b1;
    end
  end

  // Enable registers
  always_comb begin
    alert_en_d = alert_en_q;
    rpt_en_d   = rpt_en_q;
    if (wr_alert) begin
      alert_en_d = reg_wdata;
    end
    if (wr_rpt) begin
      rpt_en_d = reg_wdata;
    end
  end

  // Read path, one cycle latency
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_en) begin
      if (reg_addr == ADDR_CAL_REQ) begin
        rdata_d = cal_req_q;
      end else if (reg_addr == ADDR_ALERT_EN) begin
        rdata_d = alert_en_q;
      end else if (reg_addr == ADDR_RPT_EN) begin
        rdata_d = rpt_en_q;
      end else begin
        rdata_d = UNMAPPED_RD;
      end
    end
  end

  // 35 ms step divider
  always_comb begin
    tick_d = 1'b0;
    div_d  = div_q + DIV_W'(1);
    if (div_q == DIV_W'(STEP_CYCLES - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    tcae_rpt_chan #(
      .CNT_W (CNT_W)
    ) u_rpt (
      .clk             (clk),
      .arst_n          (arst_n),
      .tick            (tick_q),
      .repeat_en       (rpt_en_q[g]),
      .rel_en          (release_interrupt_enable),
      .repeat_interval (repeat_interval),
      .min_press_time  (min_press_time),
      .touched         (touch_status[g]),
      .event_q         (chan_evt[g])
    );
  end

  // Touch and release events share the same per-channel gate
  assign gated_evt = chan_evt & alert_en_q;

  // Alert latch; a new event beats a clear
  always_comb begin
    alert_d = alert_q;
    if (alert_clear) begin
      alert_d = 1'b0;
    end
    if (|gated_evt) begin
      alert_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_req_q  <= CAL_REQ_RST;
      alert_en_q <= ALERT_EN_RST;
      rpt_en_q   <= RPT_EN_RST;
      rdata_q    <= UNMAPPED_RD;
      fail_q     <= 1'b0;
      tried_q    <= '0;
      cv_q       <= '0;
      en_prev_q  <= '0;
      alert_q    <= 1'b0;
      div_q      <= '0;
      tick_q     <= 1'b0;
    end else begin
      cal_req_q  <= cal_req_d;
      alert_en_q <= alert_en_d;
      rpt_en_q   <= rpt_en_d;
      rdata_q    <= rdata_d;
      fail_q     <= fail_d;
      tried_q    <= tried_d;
      cv_q       <= cv_d;
      en_prev_q  <= en_prev_d;
      alert_q    <= alert_d;
      div_q      <= div_d;
      tick_q     <= tick_d;
    end
  end

  assign reg_rdata                 = rdata_q;
  assign calibration_value         = cv_q;
  assign analog_calibration_failed = fail_q;
  assign alert_n                   = ~alert_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_cal_write;
    wr_cal |=> (cal_req_q & $past(reg_wdata)) == $past(reg_wdata);
  endproperty
  a_cal_write: assert property (p_cal_write) else $error("Request set lost");

  property p_cal_value;
    cal_done && cal_busy |=> calibration_value[$past(cal_channel)] == $past(cal_result);
  endproperty
  a_cal_value: assert property (p_cal_value) else $error("Value not updated");

  property p_cal_clear;
    cal_done && cal_busy && !cal_bad && !wr_cal && !new_en[cal_channel]
      |=> !cal_req_q[$past(cal_channel)];
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("Success not cleared");

  property p_new_en;
    |new_en |=> (cal_req_q & $past(new_en)) == $past(new_en);
  endproperty
  a_new_en: assert property (p_new_en) else $error("New enable not requested");

  property p_fail;
    cal_done && cal_busy && cal_bad && cal_req_q[cal_channel]
      |=> analog_calibration_failed ##1 (analog_calibration_failed || $past(status_clear));
  endproperty
  a_fail: assert property (p_fail) else $error("Failure flag missing");

  property p_fail_keep;
    cal_done && cal_busy && cal_bad && cal_req_q[cal_channel] && !wr_cal
      |=> cal_req_q[$past(cal_channel)];
  endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("Failed bit cleared");

  property p_zero;
    wr_cal && new_en == '0 |=> (cal_req_q & ~$past(reg_wdata)) == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("Zero write ignored");

  property p_alert;
    (|gated_evt) |=> !alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("Alert not asserted");

  property p_alert_mask;
    alert_n && (gated_evt == '0) |=> alert_n;
  endproperty
  a_alert_mask: assert property (p_alert_mask) else $error("Masked alert");

endmodule : tcae_top
`default_nettype wire

// *** testbench/tcae_cal_engine_model.sv ***
// Purpose: Analog calibration engine model answering each start pulse
// Assumes: Start pulses arrive one at a time from the sequencer
// Notes:   Result bus shows inverted last value outside the done pulse
`timescale 1ns/1ps
`default_nettype none
module tcae_cal_engine_model (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // Test controls
  input  wire logic [7:0]             dly,
  input  wire logic [7:0]             lim_mask,
  // Engine handshake
  input  wire logic                   cal_start,
  input  wire logic [2:0]             cal_channel,
  output logic                        cal_done,
  output logic      [9:0]             cal_result
);
  logic       busy_q;
  logic [7:0] cnt_q;
  logic [2:0] ch_q;
  logic [9:0] last_q;

  // Limit hit forces full scale so the block must see a failure
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q   <= 1'b0;
      cnt_q    <= 8'h00;
      ch_q     <= 3'h0;
      last_q   <= 10'h000;
      cal_done <= 1'b0;
    end else begin
      cal_done <= 1'b0;
      if (cal_start) begin
        busy_q <= 1'b1;
        cnt_q  <= dly;
        ch_q   <= cal_channel;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q   <= 1'b0;
        cal_done <= 1'b1;
        last_q   <= lim_mask[ch_q] ? 10'h3ff : 10'(10'h100 + ch_q);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  assign cal_result = cal_done ? last_q : ~last_q;
endmodule : tcae_cal_engine_model
`default_nettype wire

// *** testbench/tb_tcae_top.sv ***
// Purpose: Self-checking bench for the calibration and alert enable block
// Assumes: Step count shortened to 4 cycles
// Notes:   Engine model answers calibration starts
`timescale 1ns/1ps
`default_nettype none
module tb_tcae_top;
  import tcae_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tcae_row_t;
  logic clk, arst_n, reg_wr_en, reg_rd_en, in_standby, in_deep_sleep;
  logic cal_start, cal_done, status_clear, analog_calibration_failed;
  logic release_interrupt_enable, alert_clear, alert_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, active_enable, standby_enable;
  logic [7:0] noise_flag, touch_status, eng_dly, lim_mask;
  logic [2:0] cal_channel;
  logic [9:0] cal_result;
  logic [3:0] repeat_interval, min_press_time;
  logic [NCH-1:0][CAL_W-1:0] calibration_value;
  int errors, checks_done, starts, s0;
  tcae_row_t rows [5] = '{'{8'h27, 8'ha5, 8'ha5}, '{8'h28, 8'h3c, 8'h3c},
    '{8'h31, 8'h55, 8'h00}, '{8'h27, 8'h5a, 8'h5a}, '{8'h28, 8'hc3, 8'hc3}};

  tcae_top #(.STEP_CYCLES(4)) dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .active_enable(active_enable), .standby_enable(standby_enable),
    .in_standby(in_standby), .in_deep_sleep(in_deep_sleep), .cal_start(cal_start),
    .cal_channel(cal_channel), .cal_done(cal_done), .cal_result(cal_result),
    .noise_flag(noise_flag), .calibration_value(calibration_value),
    .status_clear(status_clear), .analog_calibration_failed(analog_calibration_failed),
    .touch_status(touch_status), .release_interrupt_enable(release_interrupt_enable),
    .repeat_interval(repeat_interval), .min_press_time(min_press_time),
    .alert_clear(alert_clear), .alert_n(alert_n));
  tcae_cal_engine_model eng_u (.clk(clk), .arst_n(arst_n), .dly(eng_dly),
    .lim_mask(lim_mask), .cal_start(cal_start), .cal_channel(cal_channel),
    .cal_done(cal_done), .cal_result(cal_result));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cal_start === 1'b1) begin
      starts++;
    end
  end

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("reg_rdata", 10'(e), 10'(reg_rdata));
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_start(input logic [2:0] ch);
    int n;
    n = 0;
    while (cal_start !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("cal_start", 10'h001, 10'(cal_start));
    chk("cal_channel", 10'(ch), 10'(cal_channel));
    cyc(1);
  endtask : wait_start
  task automatic clr();
    @(posedge clk);
    alert_clear <= 1'b1;
    @(posedge clk);
    alert_clear <= 1'b0;
    #1;
  endtask : clr
  // Early exit when expecting an alert, full window when expecting none
  task automatic alert_win(input int n, input logic e);
    logic seen;
    int i;
    seen = 1'b0;
    for (i = 0; i < n && !(e && seen); i++) begin
      cyc(1);
      if (alert_n === 1'b0) seen = 1'b1;
    end
    chk("alert_n", 10'(e), 10'(seen));
    clr();
  endtask : alert_win
  task automatic touch(input int ch, input logic v);
    @(posedge clk);
    touch_status[ch] <= v;
  endtask : touch
  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(20 * 20000);
    errors++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    {reg_wr_en, reg_rd_en, in_standby, in_deep_sleep, status_clear, alert_clear} = '0;
    {reg_addr, reg_wdata, active_enable, standby_enable, noise_flag, touch_status} = '0;
    lim_mask = 8'h00;
    eng_dly = 8'h03;
    release_interrupt_enable = 1'b1;
    repeat_interval = 4'h1;
    min_press_time = 4'h2;
    cyc(1);
    chk("alert_n", 10'h001, 10'(alert_n));
    chk("failed", 10'h000, 10'(analog_calibration_failed));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_CAL_REQ, 8'h00);
    rd(ADDR_ALERT_EN, 8'hff);
    rd(ADDR_RPT_EN, 8'hff);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Several requests, ascending service, success clears
    wr(ADDR_CAL_REQ, 8'h85);
    wait_start(3'd0);
    wait_start(3'd2);
    wait_start(3'd7);
    cyc(10);
    rd(ADDR_CAL_REQ, 8'h00);
    for (int c = 0; c < 8; c += (c == 0) ? 2 : 5) begin
      chk("cal_value", 10'(10'h100 + c), calibration_value[c]);
    end
    chk("failed", 10'h000, 10'(analog_calibration_failed));
    // Noise on input 2, limit on input 4
    noise_flag <= 8'h02;
    lim_mask <= 8'h08;
    wr(ADDR_CAL_REQ, 8'h0a);
    wait_start(3'd1);
    wait_start(3'd3);
    cyc(10);
    rd(ADDR_CAL_REQ, 8'h0a);
    chk("failed", 10'h001, 10'(analog_calibration_failed));
    chk("cal_value", 10'h3ff, calibration_value[3]);
    @(posedge clk);
    status_clear <= 1'b1;
    noise_flag <= 8'h00;
    lim_mask <= 8'h00;
    @(posedge clk);
    status_clear <= 1'b0;
    cyc(2);
    chk("failed", 10'h000, 10'(analog_calibration_failed));
    // Host zero write in mid-run drops the pending channel
    eng_dly <= 8'd20;
    wr(ADDR_CAL_REQ, 8'h30);
    wait_start(3'd4);
    s0 = starts;
    wr(ADDR_CAL_REQ, 8'h00);
    cyc(50);
    chk("starts", 10'(s0), 10'(starts));
    rd(ADDR_CAL_REQ, 8'h00);
    // Newly enabled inputs in each power state
    eng_dly <= 8'h03;
    active_enable <= 8'h40;
    wait_start(3'd6);
    cyc(10);
    in_deep_sleep <= 1'b1;
    cyc(4);
    in_deep_sleep <= 1'b0;
    wait_start(3'd6);
    cyc(10);
    in_standby <= 1'b1;
    cyc(4);
    standby_enable <= 8'h04;
    wait_start(3'd2);
    cyc(10);
    rd(ADDR_CAL_REQ, 8'h00);
    // Alerts: only input 1 enabled, repeat off
    wr(ADDR_ALERT_EN, 8'h01);
    wr(ADDR_RPT_EN, 8'h00);
    touch(1, 1'b1);
    alert_win(20, 1'b0);
    touch(1, 1'b0);
    alert_win(20, 1'b0);
    touch(0, 1'b1);
    alert_win(10, 1'b1);
    alert_win(60, 1'b0);
    touch(0, 1'b0);
    alert_win(10, 1'b1);
    release_interrupt_enable <= 1'b0;
    touch(0, 1'b1);
    alert_win(10, 1'b1);
    touch(0, 1'b0);
    alert_win(20, 1'b0);
    // Repeat on: short touch, then press-and-hold
    release_interrupt_enable <= 1'b1;
    wr(ADDR_RPT_EN, 8'h01);
    touch(0, 1'b1);
    alert_win(10, 1'b1);
    touch(0, 1'b0);
    alert_win(10, 1'b1);
    alert_win(40, 1'b0);
    touch(0, 1'b1);
    alert_win(10, 1'b1);
    alert_win(8, 1'b0);
    alert_win(60, 1'b1);
    alert_win(4, 1'b0);
    alert_win(30, 1'b1);
    touch(0, 1'b0);
    cyc(20);
    // Mid-run reset brings standby input 3 back as newly enabled
    arst_n <= 1'b0;
    cyc(2);
    chk("alert_n", 10'h001, 10'(alert_n));
    arst_n <= 1'b1;
    wait_start(3'd2);
    rd(ADDR_RPT_EN, 8'hff);
    cyc(20);
    print_verdict();
  end
endmodule : tb_tcae_top
`default_nettype wire
